// ---- dv/fifo_dev_model.sv ----
// Behavioural 16-word ripple FIFO device on the far side of the host.
// Polls every 10 ns; the ripple delay is coarse, not the real figure.
module fifo_dev_model (
  input wire clear_all,
  input wire shift_in,
  input wire shift_out,
  input wire output_enable_n,
  input wire [3:0] write_word,
  output logic input_free = 1'b0,
  output logic output_word_valid = 1'b0,
  output wire [3:0] read_word
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] store[$];
  logic [3:0] out_reg = 4'h0;
  logic si_q = 1'b0;
  logic so_q = 1'b0;
  assign read_word = output_enable_n ? 4'hZ : out_reg;
  // One polling process owns both flags, so neither has a second driver.
  always #10 begin
    if (clear_all) begin
      store.delete();
      input_free = 1'b1;
      output_word_valid = 1'b0;
    end else begin
      if (shift_in && !si_q && input_free) begin
        store.push_back(write_word);
        input_free = 1'b0;
      end
      if (shift_out && !so_q) begin
        output_word_valid = 1'b0;
      end
      // Space returns once the strobe is low and a location is empty.
      if (!shift_in && !input_free && store.size() + output_word_valid < 16) begin
        input_free = 1'b1;
      end
      // A lone captured word stays put until its strobe falls.
      // Words ripple forward and the freed slot moves to the input end.
      if (!shift_out && !output_word_valid && store.size() > (shift_in ? 1 : 0)) begin
        out_reg = store.pop_front();
        output_word_valid = 1'b1;
      end
    end
    si_q = shift_in;
    so_q = shift_out;
  end
endmodule // fifo_dev_model

// ---- dv/ripple_fifo_host_props.sv ----
// Port checker for the ripple FIFO host controller.
// Bound from the bench top; sees only controller ports.
module ripple_fifo_host_props (
  input wire core_clk,
  input wire srst,
  input wire shift_in,
  input wire shift_out,
  input wire clear_all,
  input wire init_done,
  input wire wr_ready,
  input wire rd_valid,
  input wire rd_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  clr_hold_a: assert property ($fell(srst) |-> clear_all [*4])
    else $error("clear pulse short");
  si_gate_a: assert property ($rose(shift_in) |-> init_done && !clear_all)
    else $error("shift in too early");
  si_width_a: assert property ($rose(shift_in) |=> shift_in ##1 !shift_in)
    else $error("shift in width");
  si_gap_a: assert property ($fell(shift_in) |-> !shift_in [*5])
    else $error("shift in gap");
  so_gate_a: assert property ($rose(shift_out) |-> init_done && rd_valid)
    else $error("shift out unpaired");
  so_gap_a: assert property ($fell(shift_out) |-> !shift_out [*5])
    else $error("shift out gap");
  rdv_hold_a: assert property (rd_valid && !rd_ready |=> rd_valid)
    else $error("read word dropped");
  wr_gate_a: assert property (wr_ready |-> init_done && !shift_in)
    else $error("ready while busy");
  cover property ($rose(shift_in));
  cover property ($rose(shift_out));
  cover property ($fell(srst));
endmodule // ripple_fifo_host_props

// ---- dv/ripple_fifo_host_tb_top.sv ----
// Bench for the ripple FIFO host controller against a behavioural device.
// Assumes the 20 MHz controller clock and the device model file.
module ripple_fifo_host_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 0, srst = 1, wr_valid = 0, rd_ready = 0;
  logic [3:0] wr_data = 4'h0;
  wire wr_ready, rd_valid, shift_in, clear_all, shift_out, input_free, output_word_valid;
  wire output_enable_n, init_done;
  wire [3:0] rd_data, write_word, read_word;
  int failures = 0, checked = 0, cyc = 0;
  ripple_fifo_host u_dut (.core_clk, .srst, .wr_data, .wr_valid, .wr_ready, .rd_data, .rd_valid,
    .rd_ready, .write_word, .shift_in, .input_free, .clear_all, .shift_out, .output_word_valid,
    .read_word, .output_enable_n, .init_done);
  fifo_dev_model u_dev (.clear_all, .shift_in, .shift_out, .output_enable_n, .write_word,
    .input_free, .output_word_valid, .read_word);
  initial forever #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [3:0] g, input logic [3:0] e);
    checked++;
    if (g !== e) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic put(input logic [3:0] w);
    @(posedge core_clk);
    wr_data <= w;
    wr_valid <= 1'b1;
    do @(negedge core_clk); while (wr_ready !== 1'b1);
    @(posedge core_clk);
    wr_valid <= 1'b0;
  endtask
  task automatic get(input logic [3:0] e);
    do @(negedge core_clk); while (rd_valid !== 1'b1);
    chk(rd_data, e);
    @(posedge core_clk);
    rd_ready <= 1'b1;
    @(posedge core_clk);
    rd_ready <= 1'b0;
  endtask
  task automatic wait_init();
    do @(negedge core_clk); while (init_done !== 1'b1);
    // The output enable is registered one cycle behind init_done.
    @(negedge core_clk);
    chk({3'h0, output_enable_n}, 4'h0);
    chk({3'h0, output_word_valid}, 4'h0);
    $display("test init done");
  endtask
  task automatic fill_drain();
    for (int i = 0; i < 17; i++) put(4'(i * 7 + 1));
    repeat (30) @(negedge core_clk);
    chk({2'h0, wr_ready, input_free}, 4'h0);
    for (int i = 0; i < 17; i++) get(4'(i * 7 + 1));
    repeat (20) @(negedge core_clk);
    chk({3'h0, output_word_valid}, 4'h0);
    chk(read_word, 4'(16 * 7 + 1));
    $display("test fill_drain done");
  endtask
  task automatic reset_mid();
    put(4'hA);
    put(4'hB);
    repeat (20) @(posedge core_clk);
    srst <= 1'b1;
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    wait_init();
    chk(read_word, 4'hB);
    chk({3'h0, rd_valid}, 4'h0);
    put(4'h5);
    get(4'h5);
    $display("test reset_mid done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge core_clk);
    srst <= 1'b0;
    wait_init();
    fill_drain();
    reset_mid();
    tally_and_finish();
  end
endmodule // ripple_fifo_host_tb_top
bind ripple_fifo_host ripple_fifo_host_props u_props (.core_clk, .srst, .shift_in, .shift_out,
  .clear_all, .init_done, .wr_ready, .rd_valid, .rd_ready);

// ---- hw/fifo_host_defines.vh ----
// Constants for the host controller of a clockless 4-bit x 16-word ripple FIFO.
// Assumes a single 20 MHz core clock; included by the controller only.
`ifndef FIFO_HOST_DEFINES_VH
`define FIFO_HOST_DEFINES_VH

`define WORD_W 4
`define FIFO_DEPTH 16
`define CORE_CLK_HZ 20000000
// Least strobe high and low time, in ns, held by the controller.
`define STROBE_MIN_NS 100
`define STROBE_CYC ((`STROBE_MIN_NS * (`CORE_CLK_HZ / 1000000) + 999) / 1000)
// Least reset pulse width in ns.
`define RESET_MIN_NS 200
`define RESET_CYC ((`RESET_MIN_NS * (`CORE_CLK_HZ / 1000000) + 999) / 1000)
// Extra cycles for the device flags to pass the two-flop synchronisers.
`define SYNC_MARGIN_CYC 2

`endif

// ---- hw/ripple_fifo_host.v ----
// Host controller that drives a clockless ripple FIFO through its pins.
// Assumes the FIFO flags are asynchronous to core_clk and are synchronised here.
`include "fifo_host_defines.vh"

////////////////////////////////////////////////////////////////////////////////
module ripple_fifo_host #(
  parameter WORD_W = `WORD_W,
  parameter DEPTH = `FIFO_DEPTH
) (
  input wire core_clk,
  input wire srst,
  input wire [WORD_W-1:0] wr_data,
  input wire wr_valid,
  output wire wr_ready,
  output reg [WORD_W-1:0] rd_data,
  output reg rd_valid,
  input wire rd_ready,
  output reg [WORD_W-1:0] write_word,
  output reg shift_in,
  input wire input_free,
  output reg clear_all,
  output reg shift_out,
  input wire output_word_valid,
  input wire [WORD_W-1:0] read_word,
  output reg output_enable_n,
  output reg init_done
);

  localparam W_IDLE = 2'h0;
  localparam W_HIGH = 2'h1;
  localparam W_LOW = 2'h2;
  localparam R_IDLE = 2'h0;
  localparam R_SAMPLE = 2'h1;
  localparam R_HIGH = 2'h2;
  localparam R_LOW = 2'h3;
  localparam integer STROBE_CYC_INT = `STROBE_CYC;
  localparam integer RESET_CYC_INT = `RESET_CYC;
  localparam integer SYNC_MARGIN_INT = `SYNC_MARGIN_CYC;
  // The counters are four bits wide, so every count is cut to that width here.
  localparam [3:0] STROBE_CYC = STROBE_CYC_INT[3:0];
  localparam [3:0] RESET_CYC = RESET_CYC_INT[3:0];
  localparam [3:0] SYNC_MARGIN = SYNC_MARGIN_INT[3:0];
  // Low time after a strobe: strobe time plus the flag synchroniser delay.
  localparam [3:0] SETTLE_CYC = STROBE_CYC + SYNC_MARGIN;

  reg free_meta_reg, free_sync_reg;
  reg valid_meta_reg, valid_sync_reg;
  reg [WORD_W-1:0] rdw_meta_reg, rdw_sync_reg;
  reg [3:0] rst_cnt_reg;
  reg [1:0] wst_reg;
  reg [3:0] wcnt_reg;
  reg [1:0] rst_st_reg;
  reg [3:0] rcnt_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Counter helpers shared by the reset, write and read sequencers.
  function [3:0] count_up;
    input [3:0] cnt;
    begin
      count_up = cnt + 4'h1;
    end
  endfunction

  function reached;
    input [3:0] cnt;
    input [3:0] limit;
    begin
      reached = (cnt >= limit);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Two-flop synchronisers for the device flags and read data.
  always @(posedge core_clk) begin
    free_meta_reg <= input_free;
    free_sync_reg <= free_meta_reg;
    valid_meta_reg <= output_word_valid;
    valid_sync_reg <= valid_meta_reg;
    rdw_meta_reg <= read_word;
    rdw_sync_reg <= rdw_meta_reg;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reset pulse on the device after host reset, before any shifting.
  always @(posedge core_clk) begin
    if (srst) begin
      rst_cnt_reg <= 4'h0;
      clear_all <= 1'b1;
      init_done <= 1'b0;
    end else if (!init_done) begin
      rst_cnt_reg <= count_up(rst_cnt_reg);
      if (reached(rst_cnt_reg, RESET_CYC)) begin
        clear_all <= 1'b0;
      end
      // Wait one more settle time so the flags settle through the synchronisers.
      if (reached(rst_cnt_reg, RESET_CYC + SETTLE_CYC)) begin
        init_done <= 1'b1;
      end
    end
  end

  // A write is accepted only when the flag shows the input stage free.
  // The strobe is never parked high on a full device, so that case cannot arise.
  // Only one device is driven, so its own flags pace it; wider or deeper
  // arrangements must combine their flags outside this block.
  assign wr_ready = init_done && (wst_reg == W_IDLE) && free_sync_reg;

  ////////////////////////////////////////////////////////////////////////////////
  // Writer: the word is captured on the rising edge, held for the strobe time,
  // then the strobe is lowered so the word can ripple onward.
  always @(posedge core_clk) begin
    if (srst) begin
      wst_reg <= W_IDLE;
      wcnt_reg <= 4'h0;
      shift_in <= 1'b0;
      write_word <= {WORD_W{1'b0}};
    end else begin
      case (wst_reg)
        W_IDLE: begin
          if (wr_valid && wr_ready) begin
            write_word <= wr_data;
            wst_reg <= W_HIGH;
            wcnt_reg <= 4'h0;
          end
        end
        W_HIGH: begin
          // Data set up one cycle before the rising edge of the strobe.
          shift_in <= 1'b1;
          wcnt_reg <= count_up(wcnt_reg);
          if (reached(wcnt_reg, STROBE_CYC)) begin
            shift_in <= 1'b0;
            wst_reg <= W_LOW;
            wcnt_reg <= 4'h0;
          end
        end
        W_LOW: begin
          // The flag is stale for the synchroniser delay, so wait before trusting it.
          wcnt_reg <= count_up(wcnt_reg);
          if (reached(wcnt_reg, SETTLE_CYC)) begin
            wst_reg <= W_IDLE;
          end
        end
        default: wst_reg <= W_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Reader: enable the outputs, sample the word while output-valid is high, then
  // pulse shift-out; its falling edge pulls the next word forward.
  always @(posedge core_clk) begin
    if (srst) begin
      rst_st_reg <= R_IDLE;
      rcnt_reg <= 4'h0;
      shift_out <= 1'b0;
      output_enable_n <= 1'b1;
      rd_valid <= 1'b0;
      rd_data <= {WORD_W{1'b0}};
    end else begin
      output_enable_n <= !init_done;
      if (rd_valid && rd_ready) begin
        rd_valid <= 1'b0;
      end
      case (rst_st_reg)
        R_IDLE: begin
          // Output-valid is trusted only after reset is released.
          // Shift-out rises only for a word already shown, never parked on empty.
          if (init_done && valid_sync_reg && !rd_valid) begin
            rst_st_reg <= R_SAMPLE;
          end
        end
        R_SAMPLE: begin
          // Data passed the same synchroniser depth as the flag, plus one cycle.
          rd_data <= rdw_sync_reg;
          rd_valid <= 1'b1;
          shift_out <= 1'b1;
          rst_st_reg <= R_HIGH;
          rcnt_reg <= 4'h0;
        end
        R_HIGH: begin
          rcnt_reg <= count_up(rcnt_reg);
          if (reached(rcnt_reg, STROBE_CYC)) begin
            shift_out <= 1'b0;
            rst_st_reg <= R_LOW;
            rcnt_reg <= 4'h0;
          end
        end
        R_LOW: begin
          rcnt_reg <= count_up(rcnt_reg);
          if (reached(rcnt_reg, SETTLE_CYC)) begin
            rst_st_reg <= R_IDLE;
          end
        end
        default: rst_st_reg <= R_IDLE;
      endcase
    end
  end

endmodule // ripple_fifo_host
